// [lls_consts.svh]
// named constants for the load latency sampler
`ifndef LLS_CONSTS_SVH
`define LLS_CONSTS_SVH
`define LLS_EVT_LOAD_LAT 16'h01CD
`define LLS_LAT_ONE 16'h0001
`define LLS_LAT_MAX 16'hFFFF
`define LLS_PF_CACHE_LAT 16'h0001
`define LLS_CNT_ONE 48'h000000000001
`define LLS_DS4_UNKNOWN 5'h00
`define LLS_DS4_L1_HIT 5'h01
`define LLS_DS4_FB_MERGE 5'h02
`define LLS_DS4_L2_HIT 5'h03
`define LLS_DS4_L3_NOSNOOP 5'h04
`define LLS_DS4_XC_MISS 5'h05
`define LLS_DS4_XC_CLEAN 5'h06
`define LLS_DS4_XC_FWD 5'h07
`define LLS_DS4_LOC_FAR 5'h08
`define LLS_DS4_REM_FAR 5'h09
`define LLS_DS4_LOC_NEAR 5'h0A
`define LLS_DS4_REM_NEAR 5'h0B
`define LLS_DS4_REM_FWD 5'h0C
`define LLS_DS4_REM_HIT_MODIFIED 5'h0D
`define LLS_DS4_IO 5'h0E
`define LLS_DS4_UNCACHE 5'h0F
`define LLS_DS5_UNKNOWN 5'h00
`define LLS_DS5_L1_HIT 5'h01
`define LLS_DS5_FB_MERGE 5'h03
`define LLS_DS5_L2_HIT 5'h05
`define LLS_DS5_MQ_MERGE 5'h06
`define LLS_DS5_L3_HIT 5'h08
`define LLS_DS5_XC_FWD 5'h0C
`define LLS_DS5_XC_HIT_MODIFIED 5'h0D
`define LLS_DS5_MISS_HIT_MODIFIED 5'h0F
`define LLS_DS5_MSC_HIT 5'h10
`define LLS_DS5_MEMORY 5'h11
`endif

// [lls_core_model.sv]
// load pipeline and memory model facing the sampler
`timescale 1ns/100ps
`default_nettype none
module lls_core_model (
  input wire logic clk_in,
  output logic dispatch_out,
  output logic is_store_out,
  output logic is_demand_out,
  output logic is_sw_prefetch_out,
  output logic cache_access_out,
  output logic order_block_out,
  output logic data_return_out,
  output lls_pkg::lls_src_t data_src_out,
  output lls_pkg::lls_flags_t flags_out,
  output logic writeback_out,
  output logic retire_out
);
  initial begin
    {dispatch_out, is_store_out, is_demand_out, is_sw_prefetch_out} = 4'h0;
    {cache_access_out, order_block_out, data_return_out} = 3'h0;
    {writeback_out, retire_out} = 2'h0;
    data_src_out = lls_pkg::LLS_SRC_UNKNOWN;
    flags_out = 4'hF;
  end
  // one load: dispatch, access, return, writeback, retire (a prefetch goes from access
  // straight to retire); g idle cycles after dispatch and after a non-prefetch access, b of the latter with an ordering block
  task automatic load(input logic st, dm, pf, input lls_pkg::lls_src_t src,
      input lls_pkg::lls_flags_t fl, input int g, b);
    @(posedge clk_in);
    dispatch_out <= 1'b1;
    is_store_out <= st;
    is_demand_out <= dm;
    is_sw_prefetch_out <= pf;
    @(posedge clk_in);
    {dispatch_out, is_store_out, is_demand_out, is_sw_prefetch_out} <= 4'h0;
    repeat (g) @(posedge clk_in);
    cache_access_out <= 1'b1;
    data_src_out <= src;
    flags_out <= fl;
    @(posedge clk_in);
    cache_access_out <= 1'b0;
    data_src_out <= lls_pkg::lls_src_t'(~src);
    flags_out <= ~fl;
    if (!pf) begin
      for (int i = 0; i < g; i++) begin
        order_block_out <= (i < b);
        @(posedge clk_in);
      end
      order_block_out <= 1'b0;
      data_return_out <= 1'b1;
      data_src_out <= src;
      flags_out <= fl;
      @(posedge clk_in);
      data_return_out <= 1'b0;
      data_src_out <= lls_pkg::lls_src_t'(~src);
      flags_out <= ~fl;
      writeback_out <= 1'b1;
      @(posedge clk_in);
      writeback_out <= 1'b0;
    end
    retire_out <= 1'b1;
    @(posedge clk_in);
    retire_out <= 1'b0;
  endtask : load
endmodule : lls_core_model
`default_nettype wire

// [lls_load_latency_sampler.sv]
// load latency measurement, classification and threshold counting
`timescale 1ns/100ps
`default_nettype none
`include "lls_consts.svh"
module lls_load_latency_sampler #(
  parameter bit ENC5 = 1'b0
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic dispatch_in,
  input wire logic is_store_in,
  input wire logic is_demand_in,
  input wire logic is_sw_prefetch_in,
  input wire logic cache_access_in,
  input wire logic order_block_in,
  input wire logic data_return_in,
  input wire lls_pkg::lls_src_t data_src_in,
  input wire lls_pkg::lls_flags_t flags_in,
  input wire logic writeback_in,
  input wire logic retire_in,
  input wire logic squash_in,
  input wire logic [15:0] event_select_reg_in,
  input wire logic [15:0] load_latency_threshold_reg_in,
  input wire logic sample_enable_reg_in,
  input wire logic sample_record_group_cfg_in,
  input wire logic enhanced_format_in,
  output logic sample_valid_out,
  output lls_pkg::lls_sample_t sample_out,
  output logic [47:0] event_counter_out
);
  lls_pkg::lls_reg_t st;
  lls_pkg::lls_reg_t next_st;
  logic evt_match;
  logic over_thr;
  logic smp_ok;

  // --------------------------------------------------------------
  // source code mapping
  // --------------------------------------------------------------
  function automatic logic [4:0] map_src(input lls_pkg::lls_src_t s);
    logic [4:0] c;
    c = `LLS_DS4_UNKNOWN;
    if (ENC5) begin
      case (s)
        lls_pkg::LLS_SRC_L1_HIT: c = `LLS_DS5_L1_HIT;
        lls_pkg::LLS_SRC_FILL_BUFFER: c = `LLS_DS5_FB_MERGE;
        lls_pkg::LLS_SRC_L2_HIT: c = `LLS_DS5_L2_HIT;
        lls_pkg::LLS_SRC_L2_MISS_QUEUE: c = `LLS_DS5_MQ_MERGE;
        lls_pkg::LLS_SRC_L3_NOSNOOP: c = `LLS_DS5_L3_HIT;
        lls_pkg::LLS_SRC_CROSS_CORE_MISS: c = `LLS_DS5_L3_HIT;
        lls_pkg::LLS_SRC_CROSS_CORE_CLEAN: c = `LLS_DS5_L3_HIT;
        lls_pkg::LLS_SRC_CROSS_CORE_FWD: c = `LLS_DS5_XC_FWD;
        lls_pkg::LLS_SRC_CROSS_CORE_HIT_MODIFIED: c = `LLS_DS5_XC_HIT_MODIFIED;
        lls_pkg::LLS_SRC_REMOTE_HIT_MODIFIED: c = `LLS_DS5_MISS_HIT_MODIFIED;
        lls_pkg::LLS_SRC_MEMORY_SIDE_CACHE: c = `LLS_DS5_MSC_HIT;
        lls_pkg::LLS_SRC_MEMORY: c = `LLS_DS5_MEMORY;
        lls_pkg::LLS_SRC_LOCAL_FAR: c = `LLS_DS5_MEMORY;
        lls_pkg::LLS_SRC_REMOTE_FAR: c = `LLS_DS5_MEMORY;
        lls_pkg::LLS_SRC_LOCAL_NEAR: c = `LLS_DS5_MEMORY;
        lls_pkg::LLS_SRC_REMOTE_NEAR: c = `LLS_DS5_MEMORY;
        default: c = `LLS_DS5_UNKNOWN;
      endcase
    end else begin
      case (s)
        lls_pkg::LLS_SRC_L1_HIT: c = `LLS_DS4_L1_HIT;
        lls_pkg::LLS_SRC_FILL_BUFFER: c = `LLS_DS4_FB_MERGE;
        lls_pkg::LLS_SRC_L2_HIT: c = `LLS_DS4_L2_HIT;
        lls_pkg::LLS_SRC_L2_MISS_QUEUE: c = `LLS_DS4_L2_HIT;
        lls_pkg::LLS_SRC_L3_NOSNOOP: c = `LLS_DS4_L3_NOSNOOP;
        lls_pkg::LLS_SRC_CROSS_CORE_MISS: c = `LLS_DS4_XC_MISS;
        lls_pkg::LLS_SRC_CROSS_CORE_CLEAN: c = `LLS_DS4_XC_CLEAN;
        lls_pkg::LLS_SRC_CROSS_CORE_FWD: c = `LLS_DS4_XC_FWD;
        lls_pkg::LLS_SRC_CROSS_CORE_HIT_MODIFIED: c = `LLS_DS4_XC_FWD;
        lls_pkg::LLS_SRC_LOCAL_FAR: c = `LLS_DS4_LOC_FAR;
        lls_pkg::LLS_SRC_REMOTE_FAR: c = `LLS_DS4_REM_FAR;
        lls_pkg::LLS_SRC_LOCAL_NEAR: c = `LLS_DS4_LOC_NEAR;
        lls_pkg::LLS_SRC_MEMORY: c = `LLS_DS4_LOC_NEAR;
        lls_pkg::LLS_SRC_MEMORY_SIDE_CACHE: c = `LLS_DS4_LOC_NEAR;
        lls_pkg::LLS_SRC_REMOTE_NEAR: c = `LLS_DS4_REM_NEAR;
        lls_pkg::LLS_SRC_REMOTE_FWD: c = `LLS_DS4_REM_FWD;
        lls_pkg::LLS_SRC_REMOTE_HIT_MODIFIED: c = `LLS_DS4_REM_HIT_MODIFIED;
        lls_pkg::LLS_SRC_IO: c = `LLS_DS4_IO;
        lls_pkg::LLS_SRC_UNCACHEABLE: c = `LLS_DS4_UNCACHE;
        default: c = `LLS_DS4_UNKNOWN;
      endcase
    end
    return c;
  endfunction : map_src

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  assign evt_match = (event_select_reg_in == `LLS_EVT_LOAD_LAT);
  assign over_thr = (st.inst_cnt > load_latency_threshold_reg_in);
  assign smp_ok = sample_enable_reg_in && sample_record_group_cfg_in &&
                  enhanced_format_in;

  always_comb begin
    next_st = st;
    next_st.smp_valid = 1'b0;
    case (st.fsm)
      lls_pkg::LLS_IDLE: begin
        if (dispatch_in && is_demand_in && !is_store_in) begin
          next_st.fsm = lls_pkg::LLS_TRACK;
          next_st.inst_cnt = `LLS_LAT_ONE;
          next_st.cache_cnt = 16'h0000;
          next_st.cache_run = 1'b0;
          next_st.is_pf = is_sw_prefetch_in;
          next_st.src_code = map_src(lls_pkg::LLS_SRC_UNKNOWN);
          next_st.flags = '0;
        end
      end
      lls_pkg::LLS_TRACK: begin
        if (st.inst_cnt != `LLS_LAT_MAX) begin
          next_st.inst_cnt = st.inst_cnt + `LLS_LAT_ONE;
        end
        if (st.cache_run && !order_block_in &&
            st.cache_cnt != `LLS_LAT_MAX) begin
          next_st.cache_cnt = st.cache_cnt + `LLS_LAT_ONE;
        end
        if (cache_access_in && st.is_pf) begin
          next_st.cache_cnt = `LLS_PF_CACHE_LAT;
          next_st.src_code = map_src(lls_pkg::LLS_SRC_L1_HIT);
          next_st.flags = flags_in;
          next_st.fsm = lls_pkg::LLS_WAITRET;
        end else begin
          if (cache_access_in && !st.cache_run) begin
            next_st.cache_run = 1'b1;
            next_st.cache_cnt = `LLS_LAT_ONE;
          end
          if (data_return_in) begin
            next_st.cache_run = 1'b0;
            next_st.src_code = map_src(data_src_in);
            next_st.flags = flags_in;
          end
          if (writeback_in) begin
            next_st.cache_run = 1'b0;
            next_st.fsm = lls_pkg::LLS_WAITRET;
          end
        end
      end
      lls_pkg::LLS_WAITRET: begin
        if (retire_in) begin
          next_st.fsm = lls_pkg::LLS_IDLE;
          if (evt_match && over_thr) begin
            next_st.counter = st.counter + `LLS_CNT_ONE;
            next_st.smp_valid = smp_ok;
            if (smp_ok) begin
              next_st.smp.inst_latency = st.inst_cnt;
              next_st.smp.cache_latency = st.cache_cnt;
              next_st.smp.data_source = st.src_code;
              next_st.smp.flags = st.flags;
            end
          end
        end
      end
      default: next_st.fsm = lls_pkg::LLS_IDLE;
    endcase
    if (squash_in) begin
      next_st.fsm = lls_pkg::LLS_IDLE;
      next_st.smp_valid = 1'b0;
      next_st.counter = st.counter;
      next_st.smp = st.smp;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sample_valid_out = st.smp_valid;
  assign sample_out = st.smp;
  assign event_counter_out = st.counter;

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  a_count_event_match: assert property (
    (st.counter != $past(st.counter)) |-> $past(evt_match))
    else $error("counter moved without load latency event");
  a_count_over_thresh: assert property (
    (st.counter != $past(st.counter)) |->
      ($past(st.inst_cnt) > $past(load_latency_threshold_reg_in)))
    else $error("counter moved at or below threshold");
  a_store_not_tracked: assert property (
    (st.fsm == lls_pkg::LLS_IDLE && dispatch_in && is_store_in)
      |=> st.fsm == lls_pkg::LLS_IDLE)
    else $error("store was tracked");
  a_sample_format_ok: assert property (
    sample_valid_out |-> $past(smp_ok))
    else $error("sample without enhanced format setup");
  a_sample_on_retire: assert property (
    sample_valid_out |-> $past(retire_in) && !$past(squash_in))
    else $error("sample without retirement");
  a_inst_lat_step: assert property (
    (st.fsm == lls_pkg::LLS_TRACK && !squash_in &&
     st.inst_cnt != `LLS_LAT_MAX) |=>
      st.inst_cnt == $past(st.inst_cnt) + `LLS_LAT_ONE)
    else $error("instruction latency did not advance");
  a_cache_hold_block: assert property (
    (st.fsm == lls_pkg::LLS_TRACK && st.cache_run && order_block_in &&
     !cache_access_in && !st.is_pf && !squash_in)
      |=> st.cache_cnt == $past(st.cache_cnt))
    else $error("cache latency counted an ordering block");
  a_prefetch_l1_src: assert property (
    (st.fsm == lls_pkg::LLS_TRACK && st.is_pf && cache_access_in &&
     !squash_in) |=> st.src_code == map_src(lls_pkg::LLS_SRC_L1_HIT) &&
      st.cache_cnt == `LLS_PF_CACHE_LAT)
    else $error("prefetch not reported as L1 hit");
  a_enc_width_ok: assert property (
    sample_valid_out |-> (ENC5 || !sample_out.data_source[4]))
    else $error("code outside selected encoding");
  a_sample_lat_hold: assert property (
    !sample_valid_out |-> $stable(sample_out))
    else $error("sample record changed without new sample");
  a_squash_idle: assert property (
    squash_in |=> st.fsm == lls_pkg::LLS_IDLE && !sample_valid_out &&
      $stable(st.counter))
    else $error("squashed load still tracked or counted");

  c_sample_taken: cover property (sample_valid_out);
  c_count_no_sample: cover property (
    (st.counter != $past(st.counter)) && !sample_valid_out);
  c_prefetch_sample: cover property (sample_valid_out && $past(st.is_pf));
  c_block_pause: cover property (st.cache_run && order_block_in);
endmodule : lls_load_latency_sampler
`default_nettype wire

// [lls_load_latency_sampler_unused_marker.sv]
// empty compilation unit kept intentionally blank
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// [lls_pkg.sv]
// types of the load latency sampler
`default_nettype none
package lls_pkg;
  typedef enum logic [1:0] {
    LLS_IDLE = 2'b00,
    LLS_TRACK = 2'b01,
    LLS_WAITRET = 2'b10
  } lls_state_t;

  // origin class reported by the memory subsystem with the data
  typedef enum logic [4:0] {
    LLS_SRC_UNKNOWN = 5'h00,
    LLS_SRC_L1_HIT = 5'h01,
    LLS_SRC_FILL_BUFFER = 5'h02,
    LLS_SRC_L2_HIT = 5'h03,
    LLS_SRC_L2_MISS_QUEUE = 5'h04,
    LLS_SRC_L3_NOSNOOP = 5'h05,
    LLS_SRC_CROSS_CORE_MISS = 5'h06,
    LLS_SRC_CROSS_CORE_CLEAN = 5'h07,
    LLS_SRC_CROSS_CORE_FWD = 5'h08,
    LLS_SRC_CROSS_CORE_HIT_MODIFIED = 5'h09,
    LLS_SRC_LOCAL_FAR = 5'h0A,
    LLS_SRC_REMOTE_FAR = 5'h0B,
    LLS_SRC_LOCAL_NEAR = 5'h0C,
    LLS_SRC_REMOTE_NEAR = 5'h0D,
    LLS_SRC_REMOTE_FWD = 5'h0E,
    LLS_SRC_REMOTE_HIT_MODIFIED = 5'h0F,
    LLS_SRC_MEMORY_SIDE_CACHE = 5'h10,
    LLS_SRC_MEMORY = 5'h11,
    LLS_SRC_IO = 5'h12,
    LLS_SRC_UNCACHEABLE = 5'h13
  } lls_src_t;

  typedef struct packed {
    logic second_level_tlb_miss;
    logic locked;
    logic data_block;
    logic address_block;
  } lls_flags_t;

  typedef struct packed {
    logic [15:0] inst_latency;
    logic [15:0] cache_latency;
    logic [4:0] data_source;
    lls_flags_t flags;
  } lls_sample_t;

  typedef struct packed {
    lls_state_t fsm;
    logic [15:0] inst_cnt;
    logic [15:0] cache_cnt;
    logic cache_run;
    logic is_pf;
    logic [4:0] src_code;
    lls_flags_t flags;
    logic smp_valid;
    lls_sample_t smp;
    logic [47:0] counter;
  } lls_reg_t;
endpackage : lls_pkg
`default_nettype wire

// [test_load_latency_sampler.sv]
// self-checking bench of the load latency sampler
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("wrong value at %0t: %h %h", $time, a, b); end end
module test_load_latency_sampler;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic squash_in = 1'b0;
  logic dispatch_in, is_store_in, is_demand_in, is_sw_prefetch_in;
  logic cache_access_in, order_block_in, data_return_in;
  logic writeback_in, retire_in, sample_valid_out, sv5;
  lls_pkg::lls_src_t data_src_in;
  lls_pkg::lls_flags_t flags_in;
  logic [15:0] event_select_reg_in = 16'h01CD;
  logic [15:0] load_latency_threshold_reg_in = 16'h0001;
  logic sample_enable_reg_in = 1'b1;
  logic sample_record_group_cfg_in = 1'b1;
  logic enhanced_format_in = 1'b1;
  lls_pkg::lls_sample_t sample_out, s5;
  logic [47:0] event_counter_out, c5, cnt;
  int n_fail = 0, checked = 0, cycles = 0;
  localparam logic [4:0] e4_map [20] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h03,
    5'h04, 5'h05, 5'h06, 5'h07, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C,
    5'h0D, 5'h0A, 5'h0A, 5'h0E, 5'h0F};
  localparam logic [4:0] e5_map [20] = '{5'h00, 5'h01, 5'h03, 5'h05, 5'h06,
    5'h08, 5'h08, 5'h08, 5'h0C, 5'h0D, 5'h11, 5'h11, 5'h11, 5'h11, 5'h00,
    5'h0F, 5'h10, 5'h11, 5'h00, 5'h00};
  lls_load_latency_sampler #(.ENC5(1'b0)) dut (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .dispatch_in(dispatch_in),
    .is_store_in(is_store_in),
    .is_demand_in(is_demand_in),
    .is_sw_prefetch_in(is_sw_prefetch_in),
    .cache_access_in(cache_access_in),
    .order_block_in(order_block_in),
    .data_return_in(data_return_in),
    .data_src_in(data_src_in),
    .flags_in(flags_in),
    .writeback_in(writeback_in),
    .retire_in(retire_in),
    .squash_in(squash_in),
    .event_select_reg_in(event_select_reg_in),
    .load_latency_threshold_reg_in(load_latency_threshold_reg_in),
    .sample_enable_reg_in(sample_enable_reg_in),
    .sample_record_group_cfg_in(sample_record_group_cfg_in),
    .enhanced_format_in(enhanced_format_in),
    .sample_valid_out(sample_valid_out),
    .sample_out(sample_out),
    .event_counter_out(event_counter_out)
  );
  lls_load_latency_sampler #(.ENC5(1'b1)) dut5 (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .dispatch_in(dispatch_in),
    .is_store_in(is_store_in),
    .is_demand_in(is_demand_in),
    .is_sw_prefetch_in(is_sw_prefetch_in),
    .cache_access_in(cache_access_in),
    .order_block_in(order_block_in),
    .data_return_in(data_return_in),
    .data_src_in(data_src_in),
    .flags_in(flags_in),
    .writeback_in(writeback_in),
    .retire_in(retire_in),
    .squash_in(squash_in),
    .event_select_reg_in(event_select_reg_in),
    .load_latency_threshold_reg_in(load_latency_threshold_reg_in),
    .sample_enable_reg_in(sample_enable_reg_in),
    .sample_record_group_cfg_in(sample_record_group_cfg_in),
    .enhanced_format_in(enhanced_format_in),
    .sample_valid_out(sv5),
    .sample_out(s5),
    .event_counter_out(c5)
  );
  lls_core_model core (
    .clk_in(clk_in),
    .dispatch_out(dispatch_in),
    .is_store_out(is_store_in),
    .is_demand_out(is_demand_in),
    .is_sw_prefetch_out(is_sw_prefetch_in),
    .cache_access_out(cache_access_in),
    .order_block_out(order_block_in),
    .data_return_out(data_return_in),
    .data_src_out(data_src_in),
    .flags_out(flags_in),
    .writeback_out(writeback_in),
    .retire_out(retire_in)
  );
  always #50 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic run(input logic st, dm, pf, input lls_pkg::lls_src_t src,
      input lls_pkg::lls_flags_t fl, input int g, b, input logic up, smp,
      input logic [4:0] e4, e5);
    core.load(st, dm, pf, src, fl, g, b);
    #1;
    if (up) cnt++;
    `CHK(event_counter_out, cnt)
    `CHK(c5, cnt)
    `CHK(sample_valid_out, smp)
    `CHK(sv5, smp)
    if (smp) begin
      if (!pf) `CHK(sample_out.inst_latency, 16'(2 * g + 4))
      `CHK(sample_out.cache_latency, pf ? 16'h0001 : 16'(g + 2 - b))
      `CHK(sample_out.data_source, e4)
      `CHK(s5.data_source, e5)
      `CHK(sample_out.flags, fl)
    end
    @(posedge clk_in);
    #1;
    `CHK(sample_valid_out, 1'b0)
  endtask : run
  task automatic t_sources;
    for (int i = 0; i < 20; i++) begin
      run(0, 1, 0, lls_pkg::lls_src_t'(i), 4'(i), 0, 0, 1, 1, e4_map[i],
        e5_map[i]);
    end
  endtask : t_sources
  task automatic t_threshold;
    @(posedge clk_in);
    load_latency_threshold_reg_in <= 16'h000A;
    run(0, 1, 0, lls_pkg::LLS_SRC_L2_HIT, 4'h5, 3, 2, 0, 0, 5'h03, 5'h05);
    @(posedge clk_in);
    load_latency_threshold_reg_in <= 16'h0009;
    run(0, 1, 0, lls_pkg::LLS_SRC_L2_HIT, 4'h5, 3, 2, 1, 1, 5'h03, 5'h05);
    @(posedge clk_in);
    load_latency_threshold_reg_in <= 16'h0001;
  endtask : t_threshold
  task automatic t_refused;
    run(1, 1, 0, lls_pkg::LLS_SRC_L1_HIT, 4'h1, 1, 0, 0, 0, 5'h01, 5'h01);
    run(0, 0, 0, lls_pkg::LLS_SRC_L1_HIT, 4'h1, 1, 0, 0, 0, 5'h01, 5'h01);
    @(posedge clk_in);
    event_select_reg_in <= 16'h02CD;
    run(0, 1, 0, lls_pkg::LLS_SRC_L1_HIT, 4'h1, 1, 0, 0, 0, 5'h01, 5'h01);
    @(posedge clk_in);
    event_select_reg_in <= 16'h01CD;
  endtask : t_refused
  task automatic t_prefetch;
    run(0, 1, 1, lls_pkg::LLS_SRC_MEMORY, 4'hA, 2, 0, 1, 1, 5'h01, 5'h01);
  endtask : t_prefetch
  task automatic t_enables;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_in);
      {sample_enable_reg_in, sample_record_group_cfg_in,
        enhanced_format_in} <= ~(3'b100 >> k);
      run(0, 1, 0, lls_pkg::LLS_SRC_L1_HIT, 4'h3, 0, 0, 1, 0, 5'h01, 5'h01);
    end
    `CHK(sample_out.cache_latency, 16'h0001)
    `CHK(s5.flags, 4'hA)
    @(posedge clk_in);
    {sample_enable_reg_in, sample_record_group_cfg_in,
      enhanced_format_in} <= 3'b111;
  endtask : t_enables
  task automatic t_squash;
    fork
      core.load(0, 1, 0, lls_pkg::LLS_SRC_L2_HIT, 4'h5, 2, 0);
      begin
        repeat (2) @(posedge clk_in);
        squash_in <= 1'b1;
        @(posedge clk_in);
        squash_in <= 1'b0;
      end
    join
    #1;
    `CHK(event_counter_out, cnt)
    `CHK(c5, cnt)
    `CHK(sample_valid_out, 1'b0)
    `CHK(sv5, 1'b0)
  endtask : t_squash
  task stop_test;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  initial begin
    cnt = 48'h000000000000;
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'b1;
    t_sources();
    t_threshold();
    t_refused();
    t_prefetch();
    t_enables();
    t_squash();
    stop_test();
  end
endmodule : test_load_latency_sampler
`default_nettype wire
